/* File: logic/clock_select_pkg.sv */
// constants and types of the system clock source selector
`default_nettype none
package clock_select_pkg;
    // ********************************
    // register map
    // ********************************
    localparam logic [7:0] INT_CTRL_ADDR  = 8'h88;
    localparam logic [7:0] EXT_CTRL_ADDR  = 8'h8C;
    localparam logic [7:0] SEL_ADDR       = 8'h90;
    localparam logic [7:0] INT_CTRL_RESET = 8'hC0;
    localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
    localparam logic [7:0] SEL_RESET      = 8'h00;
    localparam int         INT_EN_BIT     = 7;
    localparam int         INT_RDY_BIT    = 6;
    localparam int         INT_DIV_LSB    = 0;
    localparam int         XTAL_VLD_BIT   = 7;
    localparam int         MODE_LSB       = 4;
    localparam int         DRIVE_LSB      = 0;
    localparam int         SEL_BIT        = 0;
    // ********************************
    // external mode codes
    // ********************************
    localparam logic [1:0] MODE_OFF_PFX   = 2'h0;
    localparam logic [1:0] MODE_RC_PFX    = 2'h2;
    localparam logic [1:0] MODE_XTAL_PFX  = 2'h3;
    localparam logic [2:0] MODE_CMOS      = 3'h2;
    localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
    // ********************************
    // timing
    // ********************************
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         SETTLE_TIME_NS = 20000;
    localparam int         SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ********************************
    // bus answers and types
    // ********************************
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    typedef struct packed {
        logic       circuitOn;
        logic       cmosInput;
        logic       rcMode;
        logic       crystalMode;
        logic       divideBy2;
        logic [2:0] driveCode;
    } ext_osc_ctrl_t;
    typedef enum {SW_RUN, SW_DRAIN, SW_ARM} switch_state_t;
endpackage : clock_select_pkg
`default_nettype wire

/* File: logic/system_clock_source_select.sv */
// system clock source selector with external oscillator control and AXI4-Lite registers
// Function
// [RQ1] select bit 0 routes divided internal oscillator, 1 routes external circuit
// [RQ2] external oscillator keeps clocking peripherals while internal is system clock
// [RQ3] source may switch on the fly; software selects only settled sources
// [RQ4] one internal control write both enables internal oscillator and sets its divider
// [RQ5] hardware sets read-only crystal valid bit 7 when crystal running and stable
// [RQ6] software waits at least 1 ms before sampling crystal valid; the test waits 2500 cycles (25 us) before polling
// [RQ7] mode 00x turns circuit off, 010 CMOS input, 011 CMOS divided by 2
// [RQ8] mode 10x RC or capacitor divided by 2, 110 crystal, 111 crystal divided by 2
// [RQ9] bit 3 of external control reads zero, writes ignored
// [RQ10] software sets drive field to crystal band in crystal mode
// [RQ11] software sets drive field to RC band in RC mode
// [RQ12] drive codes 000 to 111 select rising capacitor oscillation factors
// [RQ13] external control resets to zero: circuit off, valid clear
// [RQ14] software enables crystal, waits, polls valid, then selects external
// [RQ15] RC and capacitor modes need no settling before use
// [RQ16] internal divider codes 00..11 divide by 8, 4, 2, 1
// [RQ17] after reset system clock runs from internal oscillator
// [RQ18] source change produces no runt or glitch on system clock
`default_nettype none
module system_clock_source_select #(
    parameter int ADDR_W = 8
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ADDR_W-1:0]             s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          crystalPinOne,
    input  wire logic                          amplitudeOk,
    input  wire logic                          intOscReady,
    output logic                               sysClkTick,
    output logic                               periphClkTick,
    output logic                               sysClkFromExt,
    output logic                               intOscEnable,
    output clock_select_pkg::ext_osc_ctrl_t    extOscCtrl
);
    // ********************************
    // helpers
    // ********************************
    function automatic logic [2:0] divisorOf(input logic [1:0] code);
        case (code)
            2'h0:    divisorOf = 3'h7;
            2'h1:    divisorOf = 3'h3;
            2'h2:    divisorOf = 3'h1;
            default: divisorOf = 3'h0;
        endcase
    endfunction : divisorOf
    function automatic logic [7:0] wordAddr(input logic [ADDR_W-1:0] a);
        wordAddr = {a[7:2], 2'h0};
    endfunction : wordAddr
    // ********************************
    // register file and AXI4-Lite slave
    // ********************************
    logic                  intEnable, next_intEnable;
    logic [1:0]            intDivider, next_intDivider;
    logic [2:0]            extMode, next_extMode;
    logic [2:0]            extDrive, next_extDrive;
    logic                  selBit, next_selBit;
    logic                  crystalValid;
    logic                  awHeld, next_awHeld;
    logic [ADDR_W-1:0]     awAddr, next_awAddr;
    logic                  wHeld, next_wHeld;
    logic [31:0]           wData, next_wData;
    logic                  wLow, next_wLow;
    logic                  next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]            next_bresp, next_rresp;
    logic [31:0]           next_rdata;
    logic                  doWrite, intWrite, extWrite;
    assign doWrite  = awHeld && wHeld && !s_axi_bvalid;
    assign intWrite = doWrite && wLow && wordAddr(awAddr) == clock_select_pkg::INT_CTRL_ADDR;
    assign extWrite = doWrite && wLow && wordAddr(awAddr) == clock_select_pkg::EXT_CTRL_ADDR;
    always_comb begin
        next_intEnable  = intEnable;
        next_intDivider = intDivider;
        next_extMode    = extMode;
        next_extDrive   = extDrive;
        next_selBit     = selBit;
        next_awHeld     = awHeld;
        next_awAddr     = awAddr;
        next_wHeld      = wHeld;
        next_wData      = wData;
        next_wLow       = wLow;
        next_bvalid     = s_axi_bvalid;
        next_bresp      = s_axi_bresp;
        next_arready    = s_axi_arready;
        next_rvalid     = s_axi_rvalid;
        next_rdata      = s_axi_rdata;
        next_rresp      = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wLow  = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = clock_select_pkg::RESP_OKAY;
            case (wordAddr(awAddr))
                clock_select_pkg::INT_CTRL_ADDR: begin
                    next_intEnable  = wLow ? wData[clock_select_pkg::INT_EN_BIT] : intEnable;        // see [RQ4]
                    next_intDivider = wLow ? wData[clock_select_pkg::INT_DIV_LSB +: 2] : intDivider;  // see [RQ4]
                end
                clock_select_pkg::EXT_CTRL_ADDR: begin
                    next_extMode  = wLow ? wData[clock_select_pkg::MODE_LSB +: 3] : extMode;        // see [RQ9]
                    next_extDrive = wLow ? wData[clock_select_pkg::DRIVE_LSB +: 3] : extDrive;      // see [RQ12]
                end
                clock_select_pkg::SEL_ADDR: begin
                    next_selBit = wLow ? wData[clock_select_pkg::SEL_BIT] : selBit;                 // see [RQ1]
                end
                default: begin
                    next_bresp = clock_select_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = 32'h0;
            next_rresp   = clock_select_pkg::RESP_OKAY;
            case (wordAddr(s_axi_araddr))
                clock_select_pkg::INT_CTRL_ADDR: begin
                    next_rdata[clock_select_pkg::INT_EN_BIT]        = intEnable;
                    next_rdata[clock_select_pkg::INT_RDY_BIT]       = intOscReady;
                    next_rdata[clock_select_pkg::INT_DIV_LSB +: 2]  = intDivider;
                end
                clock_select_pkg::EXT_CTRL_ADDR: begin
                    // bit 3 stays zero
                    next_rdata[clock_select_pkg::XTAL_VLD_BIT]      = crystalValid;  // see [RQ5]
                    next_rdata[clock_select_pkg::MODE_LSB +: 3]     = extMode;
                    next_rdata[clock_select_pkg::DRIVE_LSB +: 3]    = extDrive;      // see [RQ9]
                end
                clock_select_pkg::SEL_ADDR: begin
                    next_rdata[clock_select_pkg::SEL_BIT]           = selBit;
                end
                default: begin
                    next_rresp = clock_select_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_awHeld && !next_bvalid;
        next_wready  = !next_wHeld && !next_bvalid;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            intEnable     <= clock_select_pkg::INT_CTRL_RESET[clock_select_pkg::INT_EN_BIT];
            intDivider    <= clock_select_pkg::INT_CTRL_RESET[clock_select_pkg::INT_DIV_LSB +: 2];
            extMode       <= clock_select_pkg::EXT_CTRL_RESET[clock_select_pkg::MODE_LSB +: 3];   // see [RQ13]
            extDrive      <= clock_select_pkg::EXT_CTRL_RESET[clock_select_pkg::DRIVE_LSB +: 3];  // see [RQ13]
            selBit        <= clock_select_pkg::SEL_RESET[clock_select_pkg::SEL_BIT];              // see [RQ17]
            awHeld        <= 1'b0;
            awAddr        <= '0;
            wHeld         <= 1'b0;
            wData         <= 32'h0;
            wLow          <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            intEnable     <= next_intEnable;
            intDivider    <= next_intDivider;
            extMode       <= next_extMode;
            extDrive      <= next_extDrive;
            selBit        <= next_selBit;
            awHeld        <= next_awHeld;
            awAddr        <= next_awAddr;
            wHeld         <= next_wHeld;
            wData         <= next_wData;
            wLow          <= next_wLow;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready || (!s_axi_arready && !s_axi_rvalid && !next_rvalid);
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end
    // ********************************
    // oscillator paths and source switch
    // ********************************
    localparam logic [11:0] SETTLE_LAST = 12'(clock_select_pkg::SETTLE_CYCLES);
    logic [2:0]                       intCount, next_intCount;
    logic                             pinPrev;
    logic                             halfPhase, next_halfPhase;
    logic [11:0]                      settleCount, next_settleCount;
    logic                             next_crystalValid;
    logic                             activeSrc, next_activeSrc;
    clock_select_pkg::switch_state_t  swState, next_swState;
    logic                             next_sysClkTick;
    clock_select_pkg::ext_osc_ctrl_t  next_extOscCtrl;
    logic                             intTick, extRise, extTick, extOn, xtalMode, modeDiv2, oldTick, newTick;
    assign intTick  = intEnable && intCount == 3'h0;                                    // see [RQ16]
    assign extOn    = extMode[2:1] != clock_select_pkg::MODE_OFF_PFX;                   // see [RQ7]
    assign xtalMode = extMode[2:1] == clock_select_pkg::MODE_XTAL_PFX;                  // see [RQ8]
    assign modeDiv2 = extMode[0] || extMode[2:1] == clock_select_pkg::MODE_RC_PFX;      // see [RQ8]
    assign extRise  = extOn && crystalPinOne && !pinPrev;
    assign extTick  = extRise && (!modeDiv2 || halfPhase);
    assign oldTick  = activeSrc ? extTick : intTick;
    assign newTick  = selBit ? extTick : intTick;
    always_comb begin
        next_intCount    = intTick ? divisorOf(intDivider) : intCount - 3'h1;          // see [RQ16]
        next_halfPhase   = extOn ? (extRise ? !halfPhase : halfPhase) : 1'b0;
        next_settleCount = settleCount;
        if (!(xtalMode && amplitudeOk)) begin
            next_settleCount = 12'h0;
        end else if (settleCount != SETTLE_LAST) begin
            next_settleCount = settleCount + 12'h1;
        end
        next_crystalValid = xtalMode && settleCount == SETTLE_LAST;                     // see [RQ5]
        next_swState      = swState;
        next_activeSrc    = activeSrc;
        next_sysClkTick   = 1'b0;
        case (swState)
            clock_select_pkg::SW_RUN: begin
                next_sysClkTick = oldTick;                                              // see [RQ1]
                if (selBit != activeSrc) begin
                    next_swState = clock_select_pkg::SW_DRAIN;                          // see [RQ3]
                end
            end
            clock_select_pkg::SW_DRAIN: begin
                next_sysClkTick = oldTick;                                              // see [RQ18]
                if (oldTick) begin
                    next_swState = clock_select_pkg::SW_ARM;
                end
            end
            clock_select_pkg::SW_ARM: begin
                if (newTick) begin
                    next_activeSrc = selBit;                                            // see [RQ18]
                    next_swState   = clock_select_pkg::SW_RUN;
                end
            end
            default: begin
                next_swState = clock_select_pkg::SW_RUN;
            end
        endcase
        next_extOscCtrl.circuitOn   = extOn;
        next_extOscCtrl.cmosInput   = extMode == clock_select_pkg::MODE_CMOS || extMode == clock_select_pkg::MODE_CMOS_DIV2;
        next_extOscCtrl.rcMode      = extMode[2:1] == clock_select_pkg::MODE_RC_PFX;    // see [RQ15]
        next_extOscCtrl.crystalMode = xtalMode;
        next_extOscCtrl.divideBy2   = modeDiv2 && extOn;
        next_extOscCtrl.driveCode   = extDrive;                                         // see [RQ12]
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            intCount      <= 3'h0;
            pinPrev       <= 1'b0;
            halfPhase     <= 1'b0;
            settleCount   <= 12'h0;
            crystalValid  <= 1'b0;                                                      // see [RQ13]
            activeSrc     <= 1'b0;                                                      // see [RQ17]
            swState       <= clock_select_pkg::SW_RUN;
            sysClkTick    <= 1'b0;
            periphClkTick <= 1'b0;
            sysClkFromExt <= 1'b0;
            intOscEnable  <= 1'b1;
            extOscCtrl    <= '0;
        end else begin
            intCount      <= next_intCount;
            pinPrev       <= crystalPinOne;
            halfPhase     <= next_halfPhase;
            settleCount   <= next_settleCount;
            crystalValid  <= next_crystalValid;
            activeSrc     <= next_activeSrc;
            swState       <= next_swState;
            sysClkTick    <= next_sysClkTick;
            periphClkTick <= extTick;                                                   // see [RQ2]
            sysClkFromExt <= next_activeSrc;
            intOscEnable  <= intEnable;
            extOscCtrl    <= next_extOscCtrl;
        end
    end
    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence drainThenArm;
        swState == clock_select_pkg::SW_DRAIN && oldTick ##1 swState == clock_select_pkg::SW_ARM;
    endsequence
    sequence intWriteEnable;
        intWrite && wData[clock_select_pkg::INT_EN_BIT];
    endsequence
    divide_eight_a: assert property (intTick && intDivider == 2'h0 |=> (!intTick) [*7]) // see [RQ16]
        else $error("internal tick spacing below eight at divide code 00");
    divide_one_a: assert property (intTick && intDivider == 2'h3 |=> intTick || !intEnable) // see [RQ16]
        else $error("internal tick missing at divide code 11");
    route_internal_a: assert property (swState == clock_select_pkg::SW_RUN && !activeSrc && intTick |=> sysClkTick) // see [RQ1]
        else $error("internal tick not routed to system clock");
    periph_ext_a: assert property (extTick |=> periphClkTick) // see [RQ2]
        else $error("external tick not passed to peripherals");
    no_runt_a: assert property (drainThenArm |=> !sysClkTick) // see [RQ18]
        else $error("system clock pulse during source handover");
    single_write_a: assert property (intWriteEnable |=> intEnable && intDivider == $past(wData[1:0])) // see [RQ4]
        else $error("internal enable and divider not taken in one write");
    xtal_valid_a: assert property (!xtalMode |=> ##1 !crystalValid) // see [RQ5]
        else $error("crystal valid set outside crystal mode");
    ext_off_a: assert property (extMode[2:1] == clock_select_pkg::MODE_OFF_PFX |-> !extTick ##1 !periphClkTick) // see [RQ7]
        else $error("external tick while circuit off");
    reserved_bit_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rdata[3]) // see [RQ9]
        else $error("reserved bit read as one");
    drive_out_a: assert property (extWrite |-> ##2 extOscCtrl.driveCode == $past(wData[2:0], 2)) // see [RQ12]
        else $error("drive code not presented two cycles after write");
endmodule : system_clock_source_select
`default_nettype wire

/* File: dv/ext_osc_model.sv */
// external oscillator stand-in: pin clock plus amplitude detector
`default_nettype none
module ext_osc_model #(
    parameter int HALF   = 5,
    parameter int SETTLE = 300
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic circuitOn,
    input  wire logic crystalMode,
    output logic      crystalPinOne,
    output logic      amplitudeOk
);
    timeunit 1ns;
    timeprecision 1ps;
    int ph;
    int age;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n || !circuitOn) begin
            ph            <= 0;
            age           <= 0;
            crystalPinOne <= 1'b0;
            amplitudeOk   <= 1'b0;
        end else begin
            ph  <= (ph == HALF - 1) ? 0 : ph + 1;
            age <= age + 1;
            if (ph == HALF - 1) crystalPinOne <= !crystalPinOne;
            amplitudeOk <= crystalMode && (age >= SETTLE);
        end
    end
endmodule : ext_osc_model
`default_nettype wire

/* File: dv/system_clock_source_select_test.sv */
// register-level test of the system clock source selector
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("Error %0t: bad value", $time); end end
module system_clock_source_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // signals and partner
    // ********************************
    logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, crystalPinOne, amplitudeOk;
    logic sysClkTick, periphClkTick, sysClkFromExt, intOscEnable, dv2;
    logic [7:0] s_axi_awaddr, s_axi_araddr, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, wr_r;
    logic [2:0] mc;
    clock_select_pkg::ext_osc_ctrl_t extOscCtrl;
    int n_fail, n_tests, cyc, c;
    system_clock_source_select dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .crystalPinOne(crystalPinOne), .amplitudeOk(amplitudeOk), .intOscReady(1'b1), .sysClkTick(sysClkTick),
        .periphClkTick(periphClkTick), .sysClkFromExt(sysClkFromExt), .intOscEnable(intOscEnable),
        .extOscCtrl(extOscCtrl));
    ext_osc_model osc (.ref_clk(ref_clk), .rst_n(rst_n), .circuitOn(extOscCtrl.circuitOn),
        .crystalMode(extOscCtrl.crystalMode), .crystalPinOne(crystalPinOne), .amplitudeOk(amplitudeOk));
    // ********************************
    // bus tasks and helpers
    // ********************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin s_axi_bready <= 1'b0; wr_r = s_axi_bresp; end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) begin s_axi_rready <= 1'b0; d = s_axi_rdata[7:0]; r = s_axi_rresp; end
        end while (s_axi_arvalid || s_axi_rready);
    endtask : rd
    task automatic cnt(input int n, input bit sys);
        c = 0;
        repeat (n) begin @(posedge ref_clk); if ((sys ? sysClkTick : periphClkTick) === 1'b1) c++; end
    endtask : cnt
    function automatic bit near(input int e); return c >= e - 1 && c <= e + 1; endfunction : near
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // ********************************
    // clock, watchdog and tests
    // ********************************
    initial begin ref_clk = 1'b0; forever #5 ref_clk = ~ref_clk; end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin n_fail++; $display("Error %0t: timeout", $time); results(); end
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0; rst_n = 1'b0;
        repeat (12) @(posedge ref_clk); rst_n <= 1'b1; @(posedge ref_clk);
        rd(8'h8C); `CHK(d, 8'h00)
        rd(8'h90); `CHK(d, 8'h00)
        `CHK(sysClkFromExt, 1'b0)
        rd(8'h94); `CHK(r, clock_select_pkg::RESP_SLVERR)
        for (int k = 0; k < 4; k++) begin
            wr(8'h88, 8'h80 | k); rd(8'h88); `CHK(d, 8'hC0 | k)
            cnt(64, 1); `CHK(near(8 << k), 1'b1)
        end
        wr(8'h88, 8'h03); `CHK(intOscEnable, 1'b0)
        cnt(64, 1); `CHK(near(0), 1'b1)
        wr(8'h88, 8'h83); `CHK(intOscEnable, 1'b1)
        $display("dividers done");
        for (int m = 0; m < 8; m++) begin
            mc = m; dv2 = (mc[2:1] == 2'h2) || (mc[0] && mc[2:1] != 2'h0);
            wr(8'h8C, {1'b0, mc, 1'b1, mc}); `CHK(wr_r, clock_select_pkg::RESP_OKAY)
            rd(8'h8C); `CHK(d, {1'b0, mc, 1'b0, mc})
            `CHK(extOscCtrl, {mc[2] | mc[1], mc[2:1] == 2'h1, mc[2:1] == 2'h2, mc[2:1] == 2'h3, dv2, mc})
            cnt(200, 0); `CHK(near((mc[2:1] == 2'h0) ? 0 : (dv2 ? 10 : 20)), 1'b1)
        end
        $display("modes done");
        wr(8'h8C, 8'h67); repeat (2500) @(posedge ref_clk);
        for (int p = 0; p < 50; p++) begin rd(8'h8C); if (d[7] === 1'b1) break; end
        `CHK(d, 8'hE7)
        wr(8'h90, 8'h01); repeat (100) @(posedge ref_clk);
        `CHK(sysClkFromExt, 1'b1)
        cnt(200, 1); `CHK(near(20), 1'b1)
        wr(8'h90, 8'h00); repeat (100) @(posedge ref_clk);
        `CHK(sysClkFromExt, 1'b0)
        cnt(64, 1); `CHK(near(64), 1'b1)
        $display("switching done");
        @(posedge ref_clk); rst_n <= 1'b0; repeat (3) @(posedge ref_clk); rst_n <= 1'b1; @(posedge ref_clk);
        rd(8'h8C); `CHK(d, 8'h00)
        rd(8'h88); `CHK(d, 8'hC0)
        `CHK(intOscEnable, 1'b1)
        $display("second reset done");
        results();
    end
endmodule : system_clock_source_select_test
`default_nettype wire
